/* hdl/mmmc_ctrl.sv */
// The APB slave port is this design's own decision.
`include "mmmc_params.svh"

module mmmc_ctrl #(
   parameter logic [3:0] FLASH_PAGE_MIN = `MMMC_FLASH_PAGE_MIN
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Pins and status
   input wire logic mode_config_pin_i,
   input wire logic secured_i,
   input wire logic bdm_exit_i,
   output logic bdm_active_o,
   output logic mode_special_o,
   output logic sys_reset_req_o,
   output logic irq_o,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // CPU master
   input wire logic cpu_req_i,
   input wire logic cpu_we_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic [7:0] cpu_wdata_i,
   output logic cpu_gnt_o,
   output logic cpu_done_o,
   output logic [7:0] cpu_rdata_o,
   // Debug master
   input wire logic dbg_req_i,
   input wire logic dbg_we_i,
   input wire logic [15:0] dbg_addr_i,
   input wire logic [7:0] dbg_wdata_i,
   output logic dbg_gnt_o,
   output logic dbg_done_o,
   output logic [7:0] dbg_rdata_o,
   // Resource side
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [17:0] mem_gaddr_o,
   output logic [7:0] mem_wdata_o,
   output mmmc_pkg::mmmc_region_t mem_region_o,
   output logic mem_misaligned_o,
   input wire logic [7:0] mem_rdata_i
);
   import mmmc_pkg::*;

   mmmc_state_t st;
   mmmc_state_t next_st;

   //==============================================================
   // Decoding
   function automatic logic [3:0] page_of(input logic [15:0] a, input logic [3:0] pg);
      case (a[15:14])
         2'h0: page_of = `MMMC_PAGE_0000;
         2'h1: page_of = `MMMC_PAGE_4000;
         2'h2: page_of = pg;
         default: page_of = `MMMC_PAGE_C000;
      endcase
   endfunction

   function automatic mmmc_region_t decode(input logic [15:0] a, input logic dbg,
                                           input logic background_debug, input logic [3:0] pg);
      if (dbg && background_debug && a >= `MMMC_BDM_BASE) begin
         decode = MMMC_RG_BDM;
      end else if (a <= `MMMC_REG_END) begin
         decode = MMMC_RG_REG;
      end else if (a >= `MMMC_DFL_BASE && a <= `MMMC_DFL_END) begin
         decode = MMMC_RG_DFL;
      end else if (a >= `MMMC_RAM_BASE && a < `MMMC_FLASH_BASE) begin
         decode = MMMC_RG_RAM;
      end else if (a >= `MMMC_FLASH_BASE && page_of(a, pg) >= FLASH_PAGE_MIN) begin
         decode = MMMC_RG_PFL;
      end else begin
         decode = MMMC_RG_NONE;
      end
   endfunction

   function automatic logic [7:0] reg_index(input logic [11:0] a);
      reg_index = (a[1:0] == 2'h0) ? a[9:2] : 8'hff;
   endfunction

   //==============================================================
   // Arbitration, debug first so a halted core cannot starve it
   logic sel_dbg;
   logic [15:0] sel_addr;
   mmmc_region_t sel_region;
   logic [7:0] ridx;
   logic mapped;
   logic apb_wr;
   logic apb_setup;

   assign dbg_gnt_o = dbg_req_i; // see R06
   assign cpu_gnt_o = cpu_req_i && !dbg_req_i; // see R06
   assign sel_dbg = dbg_req_i;
   assign sel_addr = sel_dbg ? dbg_addr_i : cpu_addr_i;
   assign sel_region = decode(sel_addr, sel_dbg, st.bdm_active, st.page_index_bits); // see R07

   assign ridx = reg_index(paddr_i);
   assign mapped = (paddr_i[11:10] == 2'h0) &&
      (ridx == `MMMC_IDX_RSVD_A || ridx == `MMMC_IDX_MODE ||
       ridx == `MMMC_IDX_RSVD_10 || ridx == `MMMC_IDX_DIRECT ||
       ridx == `MMMC_IDX_RSVD_12 || ridx == `MMMC_IDX_RSVD_13 ||
       ridx == `MMMC_IDX_RSVD_14 || ridx == `MMMC_IDX_FLASH_WINDOW_PAGE ||
       ridx == `MMMC_IDX_STATE || ridx == `MMMC_IDX_IRQ_STAT ||
       ridx == `MMMC_IDX_IRQ_MASK);
   assign apb_wr = psel_i && penable_i && pwrite_i && mapped;
   assign apb_setup = psel_i && !penable_i;

   //==============================================================
   // Next state
   always_comb begin
      logic [2:0] ev;
      logic refuse;
      next_st = st;
      ev = 3'h0;
      refuse = 1'b0;

      // Pin passes two flops; the wait covers the synchroniser
      next_st.mode_s1 = mode_config_pin_i;
      next_st.mode_s2 = st.mode_s1;
      if (!st.captured) begin
         if (st.capt_cnt == `MMMC_CAPT_WAIT) begin
            next_st.captured = 1'b1;
            next_st.mode_special = st.mode_s2; // see R01 see R02 see R03
            next_st.bdm_active = st.mode_s2; // see R04
         end else begin
            next_st.capt_cnt = st.capt_cnt + 2'h1;
         end
      end
      if (bdm_exit_i) begin
         next_st.bdm_active = 1'b0;
      end

      // Resource access, stage one
      next_st.acc_valid = dbg_gnt_o || cpu_gnt_o;
      next_st.acc_dbg = sel_dbg;
      if (sel_dbg && secured_i && sel_region == MMMC_RG_PFL) begin
         refuse = 1'b1; // see R09
         ev[`MMMC_IRQ_SECURE] = 1'b1;
      end
      if (sel_region == MMMC_RG_NONE) begin
         refuse = 1'b1;
      end
      next_st.acc_refused = refuse;
      next_st.reset_req = cpu_gnt_o && sel_region == MMMC_RG_NONE; // see R08
      if (next_st.reset_req) begin
         ev[`MMMC_IRQ_ILLEGAL] = 1'b1;
      end
      next_st.mem_req = next_st.acc_valid && !refuse;
      next_st.mem_we = sel_dbg ? dbg_we_i : cpu_we_i;
      next_st.mem_gaddr = {page_of(sel_addr, st.page_index_bits), sel_addr[13:0]}; // see R05 see R13
      next_st.mem_wdata = sel_dbg ? dbg_wdata_i : cpu_wdata_i;
      next_st.mem_region = sel_region;
      next_st.mem_misaligned = sel_addr[0]; // see R10

      // Stage two, refused reads return zero
      next_st.cpu_done = st.acc_valid && !st.acc_dbg;
      next_st.dbg_done = st.acc_valid && st.acc_dbg;
      if (st.acc_valid && !st.acc_dbg) begin
         next_st.cpu_rdata = st.acc_refused ? 8'h00 : mem_rdata_i;
      end
      if (st.acc_valid && st.acc_dbg) begin
         next_st.dbg_rdata = st.acc_refused ? 8'h00 : mem_rdata_i;
      end

      // Register writes
      if (apb_wr) begin
         case (ridx)
            `MMMC_IDX_MODE: begin
               if (secured_i || (st.mode_lock && !st.mode_special)) begin
                  ev[`MMMC_IRQ_MODE_BLK] = 1'b1; // see R11
               end else if (!st.mode_special && pwdata_i[`MMMC_MODE_BIT]) begin
                  next_st.mode_lock = 1'b1; // see R11
                  ev[`MMMC_IRQ_MODE_BLK] = 1'b1;
               end else begin
                  next_st.mode_special = pwdata_i[`MMMC_MODE_BIT]; // see R11
               end
            end
            `MMMC_IDX_DIRECT: begin
               if (st.mode_special || !st.direct_written) begin
                  next_st.direct_page_bits = pwdata_i[7:0]; // see R12
                  next_st.direct_written = 1'b1;
               end
            end
            `MMMC_IDX_FLASH_WINDOW_PAGE: next_st.page_index_bits = pwdata_i[3:0];
            `MMMC_IDX_IRQ_MASK: next_st.irq_mask = pwdata_i[2:0];
            default: begin
            end
         endcase
      end

      // Sticky status, a new event wins over the clear
      if (apb_wr && ridx == `MMMC_IDX_IRQ_STAT) begin
         next_st.irq_status = st.irq_status & ~pwdata_i[2:0];
      end
      next_st.irq_status = next_st.irq_status | ev;

      // Read data is prepared in the setup phase for a zero-wait answer
      if (apb_setup) begin
         case (ridx)
            `MMMC_IDX_MODE: next_st.prdata = {24'h0, st.mode_special, 7'h00};
            `MMMC_IDX_DIRECT: next_st.prdata = {24'h0, st.direct_page_bits};
            `MMMC_IDX_FLASH_WINDOW_PAGE: next_st.prdata = {28'h0, st.page_index_bits};
            `MMMC_IDX_STATE: next_st.prdata = {27'h0, st.direct_written, st.mode_lock,
                                               st.bdm_active, st.mode_special, secured_i};
            `MMMC_IDX_IRQ_STAT: next_st.prdata = {29'h0, st.irq_status};
            `MMMC_IDX_IRQ_MASK: next_st.prdata = {29'h0, st.irq_mask};
            default: next_st.prdata = 32'h0; // see R14
         endcase
         if (paddr_i[11:10] != 2'h0) begin
            next_st.prdata = 32'h0;
         end
      end
   end

   //==============================================================
   // State register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
         st.page_index_bits <= `MMMC_FLASH_WINDOW_PAGE_RST;
         st.direct_page_bits <= `MMMC_DIRECT_RST;
         st.mem_region <= MMMC_RG_NONE;
      end else begin
         st <= next_st;
      end
   end

   //==============================================================
   // Outputs
   assign bdm_active_o = st.bdm_active;
   assign mode_special_o = st.mode_special;
   assign sys_reset_req_o = st.reset_req;
   assign irq_o = |(st.irq_status & st.irq_mask);
   assign prdata_o = st.prdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign cpu_done_o = st.cpu_done;
   assign cpu_rdata_o = st.cpu_rdata;
   assign dbg_done_o = st.dbg_done;
   assign dbg_rdata_o = st.dbg_rdata;
   assign mem_req_o = st.mem_req;
   assign mem_we_o = st.mem_we;
   assign mem_gaddr_o = st.mem_gaddr;
   assign mem_wdata_o = st.mem_wdata;
   assign mem_region_o = st.mem_region;
   assign mem_misaligned_o = st.mem_misaligned;

   //==============================================================
   // Checks
   property p_mode_capture;
      @(posedge core_clk_i) disable iff (rst_i)
      (!st.captured && st.capt_cnt == `MMMC_CAPT_WAIT) |=>
         (mode_special_o == $past(st.mode_s2)) && st.captured;
   endproperty
   a_mode_capture: assert property (p_mode_capture) // see R01
      else $error("mode not captured from pin");

   property p_debug_entry;
      @(posedge core_clk_i) disable iff (rst_i)
      ($rose(st.captured) && mode_special_o) |-> bdm_active_o;
   endproperty
   a_debug_entry: assert property (p_debug_entry) // see R04
      else $error("special mode did not enter debug");

   property p_one_grant;
      @(posedge core_clk_i) disable iff (rst_i)
      !(cpu_gnt_o && dbg_gnt_o);
   endproperty
   a_one_grant: assert property (p_one_grant) // see R06
      else $error("two masters granted");

   property p_window;
      @(posedge core_clk_i) disable iff (rst_i)
      (cpu_gnt_o && cpu_addr_i[15:14] == 2'h2 &&
       st.page_index_bits >= FLASH_PAGE_MIN) |=>
         mem_req_o && mem_gaddr_o == {$past(st.page_index_bits), $past(cpu_addr_i[13:0])};
   endproperty
   a_window: assert property (p_window) // see R13
      else $error("flash window address wrong");

   property p_illegal_reset;
      @(posedge core_clk_i) disable iff (rst_i)
      (cpu_gnt_o && decode(cpu_addr_i, 1'b0, st.bdm_active, st.page_index_bits)
         == MMMC_RG_NONE) |=> sys_reset_req_o && !mem_req_o ##1 cpu_done_o;
   endproperty
   a_illegal_reset: assert property (p_illegal_reset) // see R08
      else $error("unmapped access gave no reset");

   property p_secure_refuse;
      @(posedge core_clk_i) disable iff (rst_i)
      (dbg_gnt_o && secured_i && sel_region == MMMC_RG_PFL) |=>
         !mem_req_o ##1 (dbg_done_o && dbg_rdata_o == 8'h00);
   endproperty
   a_secure_refuse: assert property (p_secure_refuse) // see R09
      else $error("secured flash read reached memory");

   property p_misalign;
      @(posedge core_clk_i) disable iff (rst_i)
      mem_req_o |-> mem_misaligned_o == mem_gaddr_o[0];
   endproperty
   a_misalign: assert property (p_misalign) // see R10
      else $error("misaligned flag wrong");

   property p_mode_secured;
      @(posedge core_clk_i) disable iff (rst_i)
      (apb_wr && ridx == `MMMC_IDX_MODE && secured_i) |=>
         $stable(mode_special_o) && st.irq_status[`MMMC_IRQ_MODE_BLK];
   endproperty
   a_mode_secured: assert property (p_mode_secured) // see R11
      else $error("mode changed while secured");

   property p_direct_once;
      @(posedge core_clk_i) disable iff (rst_i)
      (apb_wr && ridx == `MMMC_IDX_DIRECT && !mode_special_o && st.direct_written) |=>
         $stable(st.direct_page_bits);
   endproperty
   a_direct_once: assert property (p_direct_once) // see R12
      else $error("direct page rewritten in normal mode");

   property p_reserved_zero;
      @(posedge core_clk_i) disable iff (rst_i)
      (apb_setup && (ridx == `MMMC_IDX_RSVD_A || ridx == `MMMC_IDX_RSVD_12)) |=>
         prdata_o == 32'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // see R14
      else $error("reserved location read nonzero");

endmodule

/* hdl/mmmc_params.svh */
//==============================================================
// Behaviour
// R01: Capture mode pin at reset release.
// R02: Host holds mode pin steady through reset.
// R03: Exactly two modes: normal, special single chip.
// R04: Special mode starts in active background debug.
// R05: Paging maps 256 kByte global space.
// R06: Arbitrate masters, one grant at a time.
// R07: Separate address decode for each master.
// R08: CPU unmapped access requests system reset.
// R09: Secured: debug master barred from program flash.
// R10: Even address aligned, odd address misaligned.
// R11: Mode bit writes restricted, locked, blocked secured.
// R12: Direct page: write-once normal, free special.
// R13: Page index picks flash block at 0x8000-0xBFFF.
// R14: Reserved locations read zero, ignore writes.
`ifndef MMMC_PARAMS_SVH
`define MMMC_PARAMS_SVH

//==============================================================
// Register indices, byte address is four times the index
`define MMMC_IDX_RSVD_A 8'h0a
`define MMMC_IDX_MODE 8'h0b
`define MMMC_IDX_RSVD_10 8'h10
`define MMMC_IDX_DIRECT 8'h11
`define MMMC_IDX_RSVD_12 8'h12
`define MMMC_IDX_RSVD_13 8'h13
`define MMMC_IDX_RSVD_14 8'h14
`define MMMC_IDX_FLASH_WINDOW_PAGE 8'h15
`define MMMC_IDX_STATE 8'h20
`define MMMC_IDX_IRQ_STAT 8'h21
`define MMMC_IDX_IRQ_MASK 8'h22

//==============================================================
// Fields and reset values
`define MMMC_MODE_BIT 7
`define MMMC_FLASH_WINDOW_PAGE_RST 4'he
`define MMMC_DIRECT_RST 8'h00
`define MMMC_IRQ_ILLEGAL 0
`define MMMC_IRQ_SECURE 1
`define MMMC_IRQ_MODE_BLK 2
`define MMMC_CAPT_WAIT 2'h2

//==============================================================
// Local map and fixed pages
`define MMMC_REG_END 16'h03ff
`define MMMC_DFL_BASE 16'h0400
`define MMMC_DFL_END 16'h13ff
`define MMMC_RAM_BASE 16'h2800
`define MMMC_FLASH_BASE 16'h4000
`define MMMC_BDM_BASE 16'hff00
`define MMMC_PAGE_0000 4'hc
`define MMMC_PAGE_4000 4'hd
`define MMMC_PAGE_C000 4'hf
`define MMMC_FLASH_PAGE_MIN 4'h8

`endif

/* hdl/mmmc_pkg.sv */
package mmmc_pkg;

   typedef enum logic [2:0] {
      MMMC_RG_NONE,
      MMMC_RG_REG,
      MMMC_RG_DFL,
      MMMC_RG_RAM,
      MMMC_RG_PFL,
      MMMC_RG_BDM
   } mmmc_region_t;

   typedef struct packed {
      logic mode_s1;
      logic mode_s2;
      logic [1:0] capt_cnt;
      logic captured;
      logic mode_special;
      logic mode_lock;
      logic bdm_active;
      logic [7:0] direct_page_bits;
      logic direct_written;
      logic [3:0] page_index_bits;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic [31:0] prdata;
      logic mem_req;
      logic mem_we;
      logic [17:0] mem_gaddr;
      logic [7:0] mem_wdata;
      mmmc_region_t mem_region;
      logic mem_misaligned;
      logic acc_valid;
      logic acc_dbg;
      logic acc_refused;
      logic reset_req;
      logic cpu_done;
      logic dbg_done;
      logic [7:0] cpu_rdata;
      logic [7:0] dbg_rdata;
   } mmmc_state_t;

endpackage

/* dv/mmmc_mem_model.sv */
//==============================================================
// Resource model: read data in the request cycle
module mmmc_mem_model (
   // Clock
   input wire logic core_clk_i,
   // Request
   input wire logic mem_req_i,
   input wire logic mem_we_i,
   input wire logic [17:0] mem_gaddr_i,
   // Answer
   output logic [7:0] mem_rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] data = 8'h00;
   // Toggles every cycle so stale data never looks valid
   always_ff @(posedge core_clk_i) begin
      data <= ~data;
   end
   // Controller takes read data at the end of the request cycle
   assign mem_rdata_o = (mem_req_i && !mem_we_i) ? (mem_gaddr_i[7:0] ^ 8'h5a) : data;
endmodule

/* dv/testbench.sv */
`include "mmmc_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mmmc_pkg::*;
   //==============================================================
   // Signals
   logic core_clk_i = 1'b0, rst_i = 1'b1, mode_config_pin_i = 1'b0, secured_i = 1'b0;
   logic bdm_exit_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic cpu_req_i = 1'b0, cpu_we_i = 1'b0, dbg_req_i = 1'b0, dbg_we_i = 1'b0;
   logic [15:0] cpu_addr_i = 16'h0, dbg_addr_i = 16'h0;
   logic [7:0] cpu_wdata_i = 8'h0, dbg_wdata_i = 8'h0, mem_rdata_i, cpu_rdata_o, dbg_rdata_o;
   logic [7:0] mem_wdata_o;
   logic bdm_active_o, mode_special_o, sys_reset_req_o, irq_o, pready_o, pslverr_o;
   logic cpu_gnt_o, cpu_done_o, dbg_gnt_o, dbg_done_o, mem_req_o, mem_we_o, mem_misaligned_o;
   logic [17:0] mem_gaddr_o;
   mmmc_region_t mem_region_o;
   int n_fail = 0, num_checks = 0;
   logic [3:0] m_page;
   logic [7:0] m_dp;
   logic m_dw, m_special;
   logic [31:0] rd;
   logic err;
   logic acc_we = 1'b0;
   always #2.5 core_clk_i = ~core_clk_i;
   //==============================================================
   // Instances
   mmmc_ctrl mmmc_ctrl_i (.core_clk_i, .rst_i, .mode_config_pin_i, .secured_i, .bdm_exit_i,
      .bdm_active_o, .mode_special_o, .sys_reset_req_o, .irq_o, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cpu_req_i,
      .cpu_we_i, .cpu_addr_i, .cpu_wdata_i, .cpu_gnt_o, .cpu_done_o, .cpu_rdata_o,
      .dbg_req_i, .dbg_we_i, .dbg_addr_i, .dbg_wdata_i, .dbg_gnt_o, .dbg_done_o,
      .dbg_rdata_o, .mem_req_o, .mem_we_o, .mem_gaddr_o, .mem_wdata_o, .mem_region_o,
      .mem_misaligned_o, .mem_rdata_i);
   mmmc_mem_model mmmc_mem_model_i (.core_clk_i(core_clk_i), .mem_req_i(mem_req_o),
      .mem_we_i(mem_we_o), .mem_gaddr_i(mem_gaddr_o), .mem_rdata_o(mem_rdata_i));
   //==============================================================
   // Tasks
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= {2'b00, idx, 2'b00};
      pwdata_i <= wd;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // No wait limit here, the watchdog ends a hung transfer
      do begin
         @(posedge core_clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      // Model of the paging and direct page registers
      if (w && idx == `MMMC_IDX_FLASH_WINDOW_PAGE) m_page = wd[3:0];
      if (w && idx == `MMMC_IDX_DIRECT && (m_special || !m_dw)) begin
         m_dp = wd[7:0];
         m_dw = 1'b1;
      end
      // Let the write land before anyone looks at its effect
      #1;
   endtask
   task automatic acc(input logic d, input logic [15:0] a, input mmmc_region_t er,
                      input logic ex);
      logic [3:0] pg;
      logic [17:0] g;
      logic [7:0] wd;
      pg = (a[15:14] == 2'b00) ? 4'hc : (a[15:14] == 2'b01) ? 4'hd :
           (a[15:14] == 2'b10) ? m_page : 4'hf;
      g = {pg, a[13:0]};
      wd = 8'($urandom);
      @(posedge core_clk_i);
      if (d) begin
         dbg_req_i <= 1'b1;
         dbg_addr_i <= a;
         dbg_we_i <= acc_we;
         dbg_wdata_i <= wd;
      end else begin
         cpu_req_i <= 1'b1;
         cpu_addr_i <= a;
         cpu_we_i <= acc_we;
         cpu_wdata_i <= wd;
      end
      do begin
         @(posedge core_clk_i);
      end while ((d ? dbg_gnt_o : cpu_gnt_o) !== 1'b1);
      dbg_req_i <= 1'b0;
      cpu_req_i <= 1'b0;
      dbg_we_i <= 1'b0;
      cpu_we_i <= 1'b0;
      #1;
      chk("mem_req", mem_req_o, ex);
      chk("sys_reset", sys_reset_req_o, !d && er == MMMC_RG_NONE);
      if (ex) begin
         chk("gaddr", mem_gaddr_o, g);
         chk("region", mem_region_o, er);
         chk("misaligned", mem_misaligned_o, a[0]);
         chk("we", mem_we_o, acc_we);
         chk("wdata", mem_wdata_o, wd);
      end
      @(posedge core_clk_i);
      #1;
      chk("done", d ? dbg_done_o : cpu_done_o, 1'b1);
      if (!acc_we) begin
         chk("rdata", d ? dbg_rdata_o : cpu_rdata_o, ex ? g[7:0] ^ 8'h5a : 8'h00);
      end
   endtask
   task automatic do_reset(input logic pin);
      mode_config_pin_i <= pin;
      rst_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      #1;
      m_page = 4'he;
      m_dp = 8'h00;
      m_dw = 1'b0;
      m_special = pin;
      chk("mode", mode_special_o, pin);
      chk("bdm", bdm_active_o, pin);
   endtask
   //==============================================================
   // Sequence
   initial begin
      #60000;
      n_fail++;
      final_report();
   end
   initial begin
      logic [7:0] rsv [5] = '{8'h0a, 8'h10, 8'h12, 8'h13, 8'h14};
      void'($urandom(43796));
      do_reset(1'b0);
      foreach (rsv[i]) begin
         apb(1'b1, rsv[i], 32'hffffffff);
         apb(1'b0, rsv[i], 32'h0);
         chk("reserved", rd, 32'h0);
         chk("reserved_err", err, 1'b0);
      end
      apb(1'b0, `MMMC_IDX_FLASH_WINDOW_PAGE, 32'h0);
      chk("flash_window_page_rst", rd, 32'h0000000e);
      apb(1'b0, 8'h3f, 32'h0);
      chk("unmapped_err", err, 1'b1);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `MMMC_IDX_DIRECT, 32'h80 >> i);
         apb(1'b0, `MMMC_IDX_DIRECT, 32'h0);
         chk("direct", rd, {24'h0, m_dp});
      end
      apb(1'b1, `MMMC_IDX_MODE, 32'h80);
      apb(1'b0, `MMMC_IDX_MODE, 32'h0);
      chk("mode_blocked", rd, 32'h0);
      apb(1'b0, `MMMC_IDX_IRQ_STAT, 32'h0);
      chk("irq_stat", rd, 32'h4);
      chk("irq_masked", irq_o, 1'b0);
      apb(1'b1, `MMMC_IDX_IRQ_MASK, 32'h4);
      chk("irq_on", irq_o, 1'b1);
      apb(1'b1, `MMMC_IDX_IRQ_STAT, 32'h4);
      chk("irq_clr", irq_o, 1'b0);
      repeat (8) begin
         apb(1'b1, `MMMC_IDX_FLASH_WINDOW_PAGE, {28'h0, 4'h8 | 4'($urandom % 8)});
         acc(1'b0, {2'b10, 14'($urandom)}, MMMC_RG_PFL, 1'b1);
      end
      acc(1'b0, 16'h0401, MMMC_RG_DFL, 1'b1);
      acc(1'b0, 16'h3000, MMMC_RG_RAM, 1'b1);
      acc_we = 1'b1;
      acc(1'b0, 16'h3001, MMMC_RG_RAM, 1'b1);
      acc_we = 1'b0;
      acc(1'b0, 16'h1400, MMMC_RG_NONE, 1'b0);
      apb(1'b0, `MMMC_IDX_IRQ_STAT, 32'h0);
      chk("irq_illegal", rd, 32'h1);
      @(posedge core_clk_i);
      cpu_req_i <= 1'b1;
      dbg_req_i <= 1'b1;
      @(posedge core_clk_i);
      chk("gnt_pair", {cpu_gnt_o, dbg_gnt_o}, 2'b01);
      cpu_req_i <= 1'b0;
      dbg_req_i <= 1'b0;
      do_reset(1'b1);
      acc(1'b1, 16'hff10, MMMC_RG_BDM, 1'b1);
      acc(1'b0, 16'hff10, MMMC_RG_PFL, 1'b1);
      apb(1'b1, `MMMC_IDX_DIRECT, 32'h11);
      apb(1'b1, `MMMC_IDX_DIRECT, 32'h22);
      apb(1'b0, `MMMC_IDX_DIRECT, 32'h0);
      chk("direct_ss", rd, {24'h0, m_dp});
      @(posedge core_clk_i);
      secured_i <= 1'b1;
      acc(1'b1, 16'h8002, MMMC_RG_PFL, 1'b0);
      acc(1'b0, 16'h8002, MMMC_RG_PFL, 1'b1);
      apb(1'b0, `MMMC_IDX_IRQ_STAT, 32'h0);
      chk("irq_secure", rd, 32'h2);
      apb(1'b0, `MMMC_IDX_STATE, 32'h0);
      chk("state", rd, {27'h0, m_dw, 1'b0, 1'b1, m_special, 1'b1});
      apb(1'b1, `MMMC_IDX_MODE, 32'h0);
      chk("mode_secured", mode_special_o, 1'b1);
      @(posedge core_clk_i);
      secured_i <= 1'b0;
      apb(1'b1, `MMMC_IDX_MODE, 32'h0);
      chk("mode_to_ns", mode_special_o, 1'b0);
      @(posedge core_clk_i);
      bdm_exit_i <= 1'b1;
      @(posedge core_clk_i);
      bdm_exit_i <= 1'b0;
      #1;
      chk("bdm_exit", bdm_active_o, 1'b0);
      final_report();
   end
endmodule
